// file: rtl/pbid_pkg.sv
`default_nettype none
package pbid_pkg;
	localparam logic [7:0] OFF_MSG_BASE = 8'h10;
	localparam logic [7:0] OFF_REG_BASE = 8'h14;
	localparam logic [7:0] OFF_TGT0_BASE = 8'h18;
	localparam logic [7:0] OFF_TGT1_BASE = 8'h1C;
	localparam logic [7:0] OFF_TGT2_BASE = 8'h20;
	localparam logic [7:0] OFF_TGT3_BASE = 8'h24;
	localparam logic [7:0] OFF_SUBSYS_ID = 8'h2C;
	localparam int BA64_LSB = 16;
	localparam int BA4_LSB = 12;
	localparam int PREFETCH_BIT = 3;
	localparam int MSG_LOCAL_LSB = 12;
	localparam logic PREFETCH_RST = 1'b1;
	localparam logic [15:0] BA64_RST = 16'h0000;
	localparam logic [19:0] BA4_RST = 20'h00000;
	localparam logic [31:0] SUBSYS_RST = 32'h0000_0000;
	localparam int NUM_TGT = 4;

	typedef struct packed {
		logic valid;
		logic from_pci;
		logic write;
		logic [7:0] offset;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} pbid_cfg_req_t;

	typedef struct packed {
		logic [15:0] msg_size_mask;
		logic [19:0] reg_dummy;
	} pbid_unused_t;
endpackage
`default_nettype wire

// file: rtl/pbid_bar_decode.sv
// Functional notes
// RULE1 - Message image sits on 64 KB base
// RULE2 - Queues and host registers in lowest 4 KB
// RULE3 - Message offsets above 4 KB go to processor
// RULE4 - Message image only on primary port
// RULE5 - Software programs BARs before memory accesses
// RULE6 - Zero base disables unless zero allowed
// RULE7 - Message BAR writes need its enable
// RULE8 - Register image on 4 KB base
// RULE9 - Register BAR writes need misc enable
// RULE10 - Register image prefetch reads zero
// RULE11 - Four target BARs at 0x018 to 0x024
// RULE12 - Block size field sizes each window
// RULE13 - Target BAR writes need their enables
// RULE14 - Target prefetch programmable, resets to one
// RULE15 - Space and type read as zero
// RULE16 - Subsystem register written only locally
// RULE17 - Subsystem ID high, vendor ID low
// RULE18 - Claim when enabled and upper bits match
// RULE19 - Unused low BAR bits read zero
`default_nettype none
module pbid_bar_decode (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Configuration access from PCI or local processor.
	input wire pbid_pkg::pbid_cfg_req_t cfg_req,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	// Preload values, captured one cycle after reset release.
	input wire logic eeprom_load,
	input wire logic [4:0] eeprom_prefetch,
	input wire logic [31:0] eeprom_subsys,
	// Controls from the image control and misc registers.
	input wire logic primary_port,
	input wire logic zero_base_allow,
	input wire logic regimage_base_write_enable,
	input wire logic msg_base_write_enable,
	input wire logic [3:0] tgt_base_write_enable,
	input wire logic [3:0] msg_block_size_field,
	input wire logic [15:0] tgt_block_size_field,
	// PCI memory address to decode.
	input wire logic [31:0] mem_addr,
	output logic msg_hit,
	output logic msg_local_hit,
	output logic msg_fwd_hit,
	output logic reg_hit,
	output logic [11:0] reg_index,
	output logic [3:0] tgt_hit,
	output logic [3:0] tgt_prefetch
);
	logic [15:0] msg_ba_reg;
	logic msg_pf_reg;
	logic [19:0] reg_ba_reg;
	logic [15:0] tgt_ba_reg [4];
	logic [3:0] tgt_pf_reg;
	logic [31:0] subsys_reg;
	logic [31:0] rdata_next;
	logic load_pending_reg;
	logic [31:0] msg_wmerge;
	logic [31:0] reg_wmerge;
	logic [31:0] tgt_wmerge [4];

	// Byte merge, used by the base and subsystem registers; prefetch bits take lane 0 directly.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Block size n gives a window of 64 KB shifted left n; mask of compared base bits.
	function automatic logic [15:0] size_mask(input logic [3:0] bs);
		return 16'hFFFF << bs;
	endfunction

	// Upper-bit compare of an address against a base, zero base gated.
	function automatic logic base_match(input logic [15:0] ba, input logic [15:0] a,
			input logic [3:0] bs, input logic zok);
		logic [15:0] m;
		m = size_mask(bs);
		return ((ba & m) == (a & m)) && ((ba != 16'h0000) || zok);
	endfunction

	wire logic wr = cfg_req.valid && cfg_req.write;
	wire logic [31:0] wnew = cfg_req.wdata;

	// Lanes that a write leaves out keep their old value.
	always_comb begin
		msg_wmerge = merge({msg_ba_reg, 16'h0000}, wnew, cfg_req.byte_en);
		reg_wmerge = merge({reg_ba_reg, 12'h000}, wnew, cfg_req.byte_en);
		for (int i = 0; i < pbid_pkg::NUM_TGT; i++) begin
			tgt_wmerge[i] = merge({tgt_ba_reg[i], 16'h0000}, wnew, cfg_req.byte_en);
		end
	end

	// Preload is taken on the first clock after reset, never under reset itself.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			load_pending_reg <= 1'b1;
		end else begin
			load_pending_reg <= 1'b0;
		end
	end

	// RULE7 message write gate
	// RULE1 base field 16 bits
	// RULE4 primary port only
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			msg_ba_reg <= pbid_pkg::BA64_RST;
			msg_pf_reg <= pbid_pkg::PREFETCH_RST;
		end else if (load_pending_reg && eeprom_load) begin
			msg_pf_reg <= eeprom_prefetch[4];
		end else if (wr && primary_port && msg_base_write_enable &&
				cfg_req.offset == pbid_pkg::OFF_MSG_BASE) begin
			msg_ba_reg <= msg_wmerge[31:16];
			if (cfg_req.byte_en[0]) begin
				msg_pf_reg <= wnew[pbid_pkg::PREFETCH_BIT];
			end
		end
	end

	// RULE9 register BAR gate
	// RULE8 base field 20 bits
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reg_ba_reg <= pbid_pkg::BA4_RST;
		end else if (wr && regimage_base_write_enable &&
				cfg_req.offset == pbid_pkg::OFF_REG_BASE) begin
			reg_ba_reg <= reg_wmerge[31:12];
		end
	end

	// RULE13 target write gates
	// RULE11 four consecutive BARs
	// RULE14 prefetch resets high
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < pbid_pkg::NUM_TGT; i++) begin
				tgt_ba_reg[i] <= pbid_pkg::BA64_RST;
			end
			tgt_pf_reg <= {4{pbid_pkg::PREFETCH_RST}};
		end else if (load_pending_reg && eeprom_load) begin
			tgt_pf_reg <= eeprom_prefetch[3:0];
		end else begin
			for (int i = 0; i < pbid_pkg::NUM_TGT; i++) begin
				if (wr && tgt_base_write_enable[i] &&
						cfg_req.offset == pbid_pkg::OFF_TGT0_BASE + 8'(4 * i)) begin
					tgt_ba_reg[i] <= tgt_wmerge[i][31:16];
					if (cfg_req.byte_en[0]) begin
						tgt_pf_reg[i] <= wnew[pbid_pkg::PREFETCH_BIT];
					end
				end
			end
		end
	end

	// RULE16 local writes only
	// RULE17 ID halves
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			subsys_reg <= pbid_pkg::SUBSYS_RST;
		end else if (load_pending_reg && eeprom_load) begin
			subsys_reg <= eeprom_subsys;
		end else if (wr && !cfg_req.from_pci && cfg_req.offset == pbid_pkg::OFF_SUBSYS_ID) begin
			subsys_reg <= merge(subsys_reg, wnew, cfg_req.byte_en);
		end
	end

	// RULE15 space type zero
	// RULE19 unused bits zero
	// RULE10 register prefetch zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		unique case (cfg_req.offset)
			pbid_pkg::OFF_MSG_BASE: begin
				if (primary_port) begin
					rdata_next = {msg_ba_reg, 12'h000, msg_pf_reg, 3'h0};
				end
			end
			pbid_pkg::OFF_REG_BASE: rdata_next = {reg_ba_reg, 12'h000};
			pbid_pkg::OFF_TGT0_BASE: rdata_next = {tgt_ba_reg[0], 12'h000, tgt_pf_reg[0], 3'h0};
			pbid_pkg::OFF_TGT1_BASE: rdata_next = {tgt_ba_reg[1], 12'h000, tgt_pf_reg[1], 3'h0};
			pbid_pkg::OFF_TGT2_BASE: rdata_next = {tgt_ba_reg[2], 12'h000, tgt_pf_reg[2], 3'h0};
			pbid_pkg::OFF_TGT3_BASE: rdata_next = {tgt_ba_reg[3], 12'h000, tgt_pf_reg[3], 3'h0};
			pbid_pkg::OFF_SUBSYS_ID: rdata_next = subsys_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_rdata <= 32'h0000_0000;
			cfg_ack <= 1'b0;
		end else begin
			cfg_ack <= cfg_req.valid;
			if (cfg_req.valid && !cfg_req.write) begin
				cfg_rdata <= rdata_next;
			end
		end
	end

	// RULE18 claim decode
	// RULE6 zero base gate
	// RULE12 window sizing
	always_comb begin
		msg_hit = primary_port && base_match(msg_ba_reg, mem_addr[31:16],
			msg_block_size_field, zero_base_allow);
		reg_hit = ((reg_ba_reg == mem_addr[31:12]) &&
			((reg_ba_reg != 20'h00000) || zero_base_allow));
		for (int i = 0; i < pbid_pkg::NUM_TGT; i++) begin
			tgt_hit[i] = base_match(tgt_ba_reg[i], mem_addr[31:16],
				tgt_block_size_field[i*4 +: 4], zero_base_allow);
		end
	end

	// RULE2 lowest 4 KB local
	// RULE3 above 4 KB forwarded
	assign msg_local_hit = msg_hit && (mem_addr[15:pbid_pkg::MSG_LOCAL_LSB] == 4'h0) &&
		((mem_addr[31:16] & ~size_mask(msg_block_size_field)) == 16'h0000);
	assign msg_fwd_hit = msg_hit && !msg_local_hit;
	// RULE8 register index
	assign reg_index = mem_addr[11:0];
	// RULE14 prefetch attribute out
	assign tgt_prefetch = tgt_pf_reg;

	// The decode is pure, so address to hit is checked in the same cycle.
	AST_ZERO_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
		(tgt_ba_reg[0] == 16'h0000 && !zero_base_allow) |-> !tgt_hit[0])
		else $error("Target image 0 claimed with zero base.");
	AST_MSG_SPLIT: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE3
		msg_hit |-> (msg_local_hit ^ msg_fwd_hit))
		else $error("Message image split wrong.");
	AST_MSG_LOCAL: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE2
		msg_local_hit |-> mem_addr[15:12] == 4'h0)
		else $error("Local message hit above 4 KB.");
	AST_MSG_WGATE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE7
		!msg_base_write_enable && !(load_pending_reg) |=> $stable(msg_ba_reg))
		else $error("Message base changed without enable.");
	AST_REG_WGATE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE9
		!regimage_base_write_enable |=> $stable(reg_ba_reg))
		else $error("Register base changed without enable.");
	AST_TGT_WGATE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE13
		!tgt_base_write_enable[1] |=> $stable(tgt_ba_reg[1]))
		else $error("Target base changed without enable.");
	AST_SUBSYS_PCI: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE16
		(cfg_req.valid && cfg_req.from_pci && !load_pending_reg) |=> $stable(subsys_reg))
		else $error("PCI write changed subsystem register.");
	AST_REG_READ: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE10
		(cfg_req.valid && !cfg_req.write && cfg_req.offset == pbid_pkg::OFF_REG_BASE)
		|=> cfg_ack && cfg_rdata[11:0] == 12'h000)
		else $error("Register image low bits not zero.");
	AST_REG_HIT: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE18
		reg_hit |-> mem_addr[31:12] == reg_ba_reg)
		else $error("Register image hit on wrong base.");
	AST_SECONDARY: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE4
		!primary_port |-> !msg_hit)
		else $error("Message image claimed on secondary port.");
	AST_MSG_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE7
		(wr && primary_port && msg_base_write_enable && !load_pending_reg &&
		cfg_req.offset == pbid_pkg::OFF_MSG_BASE && cfg_req.byte_en == 4'hF)
		|=> msg_ba_reg == $past(cfg_req.wdata[31:16]))
		else $error("Enabled message base write was lost.");
	AST_REG_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE9
		(wr && regimage_base_write_enable && cfg_req.offset == pbid_pkg::OFF_REG_BASE &&
		cfg_req.byte_en == 4'hF) |=> reg_ba_reg == $past(cfg_req.wdata[31:12]))
		else $error("Enabled register base write was lost.");
	AST_TGT_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE13
		(wr && tgt_base_write_enable[2] && !load_pending_reg &&
		cfg_req.offset == pbid_pkg::OFF_TGT2_BASE && cfg_req.byte_en == 4'hF)
		|=> tgt_ba_reg[2] == $past(cfg_req.wdata[31:16]))
		else $error("Enabled target base write was lost.");
	AST_TGT0_WGATE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE13
		!tgt_base_write_enable[0] |=> $stable(tgt_ba_reg[0]))
		else $error("Target 0 base changed without enable.");
	AST_TGT2_WGATE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE13
		!tgt_base_write_enable[2] |=> $stable(tgt_ba_reg[2]))
		else $error("Target 2 base changed without enable.");
	AST_TGT3_WGATE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE13
		!tgt_base_write_enable[3] |=> $stable(tgt_ba_reg[3]))
		else $error("Target 3 base changed without enable.");
	AST_SUBSYS_LOCAL: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE16
		(wr && !cfg_req.from_pci && !load_pending_reg &&
		cfg_req.offset == pbid_pkg::OFF_SUBSYS_ID && cfg_req.byte_en == 4'hF)
		|=> subsys_reg == $past(cfg_req.wdata))
		else $error("Local subsystem write was lost.");
	AST_SUBSYS_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE17
		(load_pending_reg && eeprom_load) |=> subsys_reg == $past(eeprom_subsys))
		else $error("Subsystem preload not taken.");
	AST_PF_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE14
		(load_pending_reg && eeprom_load) |=> tgt_prefetch == $past(eeprom_prefetch[3:0]))
		else $error("Target prefetch preload not taken.");
	AST_PF_KEEP: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE14
		(!load_pending_reg && !wr) |=> $stable(tgt_prefetch))
		else $error("Target prefetch changed with no write.");
	AST_MSG_READ: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE15
		(cfg_req.valid && !cfg_req.write && cfg_req.offset == pbid_pkg::OFF_MSG_BASE)
		|=> cfg_rdata[2:0] == 3'h0 && cfg_rdata[15:4] == 12'h000)
		else $error("Message base fixed bits not zero.");
	AST_TGT_READ: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE19
		(cfg_req.valid && !cfg_req.write && cfg_req.offset == pbid_pkg::OFF_TGT1_BASE)
		|=> cfg_rdata[2:0] == 3'h0 && cfg_rdata[15:4] == 12'h000)
		else $error("Target base fixed bits not zero.");
	AST_SEC_READ: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE4
		(cfg_req.valid && !cfg_req.write && !primary_port &&
		cfg_req.offset == pbid_pkg::OFF_MSG_BASE) |=> cfg_rdata == 32'h0000_0000)
		else $error("Message base visible on secondary port.");
	AST_SEC_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE4
		!primary_port |=> $stable(msg_ba_reg))
		else $error("Message base written on secondary port.");
	AST_MSG_FWD: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE3
		(msg_hit && mem_addr[15:12] != 4'h0) |-> msg_fwd_hit && !msg_local_hit)
		else $error("Message offset above 4 KB not forwarded.");
	AST_FWD_ONLY: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE3
		msg_fwd_hit |-> msg_hit && !msg_local_hit)
		else $error("Forward hit without message hit.");
	AST_LOCAL_ONLY: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE2
		msg_local_hit |-> msg_hit && !msg_fwd_hit)
		else $error("Local hit without message hit.");
	AST_ZERO_MSG: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
		(msg_ba_reg == 16'h0000 && !zero_base_allow) |-> !msg_hit)
		else $error("Message image claimed with zero base.");
	AST_ZERO_REG: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
		(reg_ba_reg == 20'h00000 && !zero_base_allow) |-> !reg_hit)
		else $error("Register image claimed with zero base.");
	AST_ZERO_TGT3: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
		(tgt_ba_reg[3] == 16'h0000 && !zero_base_allow) |-> !tgt_hit[3])
		else $error("Target image 3 claimed with zero base.");
	AST_REG_MATCH: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE8
		(reg_ba_reg != 20'h00000 && mem_addr[31:12] == reg_ba_reg) |-> reg_hit)
		else $error("Register image missed its base.");
	AST_TGT_MATCH: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE18
		(tgt_ba_reg[0] != 16'h0000 && tgt_block_size_field[3:0] == 4'h0 &&
		mem_addr[31:16] == tgt_ba_reg[0]) |-> tgt_hit[0])
		else $error("Target image 0 missed its base.");
	AST_TGT_SIZE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE12
		(tgt_block_size_field[3:0] == 4'h1 && tgt_ba_reg[0] != 16'h0000 &&
		mem_addr[31:17] == tgt_ba_reg[0][15:1]) |-> tgt_hit[0])
		else $error("Target image 0 window too small.");
	AST_MSG_BASE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE1
		(primary_port && msg_block_size_field == 4'h0 && msg_ba_reg != 16'h0000 &&
		mem_addr[31:16] == msg_ba_reg) |-> msg_hit && msg_local_hit == (mem_addr[15:12] == 4'h0))
		else $error("Message image missed its base.");
	AST_MSG_WIDE: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE12
		(msg_hit && msg_block_size_field == 4'h1 && mem_addr[16]) |-> msg_fwd_hit && !msg_local_hit)
		else $error("Wide message window offset not forwarded.");
endmodule
`default_nettype wire

// file: bench/pbid_host_model.sv
`default_nettype none
module pbid_host_model (
	// Clock.
	input wire logic clk_sys,
	// Configuration access.
	output var pbid_pkg::pbid_cfg_req_t cfg_req,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ack,
	// Memory address to decode.
	output logic [31:0] mem_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cfg_req = '0;
		mem_addr = 32'h0000_0000;
	end
	// base written first, zero base checks aside.
	// Apart from the zero base checks, callers program a base before pointing a memory address at its image.
	task automatic access(input logic pci, input logic wr, input logic [7:0] off,
		input logic [31:0] wd, output logic [31:0] rd, output logic ok);
		ok = 1'b0;
		rd = 32'h0000_0000;
		@(posedge clk_sys);
		cfg_req <= '{1'b1, pci, wr, off, 4'hF, wd};
		@(posedge clk_sys);
		// Released data is scrambled so a stale value is never mistaken for a live one.
		cfg_req <= '{1'b0, ~pci, ~wr, ~off, 4'h0, ~wd};
		for (int i = 0; i < 8 && !ok; i++) begin
			#1;
			if (cfg_ack === 1'b1) begin
				ok = 1'b1;
				rd = cfg_rdata;
			end else begin
				@(posedge clk_sys);
			end
		end
	endtask
	task automatic point(input logic [31:0] a);
		@(posedge clk_sys);
		mem_addr <= a;
		#1;
	endtask
endmodule
`default_nettype wire

// file: bench/pbid_bar_decode_bench.sv
`default_nettype none
module pbid_bar_decode_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] SUBSYS_LOAD = 32'hA5C3_1E07;
	logic clk_sys = 1'b0, sys_rst = 1'b1, primary_port = 1'b1, zba = 1'b0, eel = 1'b1;
	logic reg_we = 1'b0, msg_we = 1'b0, cfg_ack, msg_hit, msg_lh, msg_fh, reg_hit, ok;
	logic [3:0] tgt_we = 4'h0, msg_bs = 4'h0, tgt_hit, tgt_prefetch;
	logic [15:0] tgt_bs = 16'h0000;
	logic [31:0] cfg_rdata, mem_addr, rd;
	logic [11:0] reg_index;
	pbid_pkg::pbid_cfg_req_t cfg_req;
	int fails = 0, checks_done = 0;
	initial forever #2 clk_sys = ~clk_sys;
	pbid_host_model host (.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
		.cfg_ack(cfg_ack), .mem_addr(mem_addr));
	pbid_bar_decode dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .eeprom_load(eel),
		.eeprom_prefetch(5'h0E), .eeprom_subsys(SUBSYS_LOAD), .primary_port(primary_port),
		.zero_base_allow(zba), .regimage_base_write_enable(reg_we),
		.msg_base_write_enable(msg_we), .tgt_base_write_enable(tgt_we),
		.msg_block_size_field(msg_bs), .tgt_block_size_field(tgt_bs), .mem_addr(mem_addr),
		.msg_hit(msg_hit), .msg_local_hit(msg_lh), .msg_fwd_hit(msg_fh), .reg_hit(reg_hit),
		.reg_index(reg_index), .tgt_hit(tgt_hit), .tgt_prefetch(tgt_prefetch));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		if (fails == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cfg(input logic pci, input logic wr, input logic [7:0] off,
		input logic [31:0] wd);
		host.access(pci, wr, off, wd, rd, ok);
		if (!ok) begin
			fails++;
			give_verdict();
		end
	endtask
	task automatic rdchk(input logic [7:0] off, input logic [31:0] exp);
		cfg(1'b1, 1'b0, off, 32'h0000_0000);
		chk($sformatf("offset %h", off), exp, rd);
	endtask
	// Hit bits from the top: message, message local, message forward, register, targets.
	task automatic hits(input logic [31:0] a, input logic [7:0] e);
		host.point(a);
		chk("hits", {12'h000, a[11:0], e},
			{12'h000, reg_index, msg_hit, msg_lh, msg_fh, reg_hit, tgt_hit});
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("tgt_prefetch", 32'h0000_000E, {28'h0000000, tgt_prefetch});
		rdchk(8'h2C, SUBSYS_LOAD);
		rdchk(8'h18, 32'h0000_0000);
		rdchk(8'h30, 32'h0000_0000);
		hits(32'h0000_0ABC, 8'h00);
		@(posedge clk_sys);
		zba <= 1'b1;
		hits(32'h0000_0ABC, 8'hDF);
		@(posedge clk_sys);
		zba <= 1'b0;
		cfg(1'b1, 1'b1, 8'h2C, 32'h1111_2222);
		rdchk(8'h2C, SUBSYS_LOAD);
		cfg(1'b0, 1'b1, 8'h2C, 32'hBEEF_0042);
		rdchk(8'h2C, 32'hBEEF_0042);
		cfg(1'b1, 1'b1, 8'h14, 32'hFFFF_FFFF);
		rdchk(8'h14, 32'h0000_0000);
		@(posedge clk_sys);
		reg_we <= 1'b1;
		cfg(1'b1, 1'b1, 8'h14, 32'hFFFF_FFFF);
		rdchk(8'h14, 32'hFFFF_F000);
		hits(32'hFFFF_F123, 8'h10);
		hits(32'hFFFF_E123, 8'h00);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			tgt_we <= 4'h1 << i;
			cfg(1'b0, 1'b1, 8'h18 + 8'(4 * i), {16'h1000 + 16'(i), 16'h0008});
			cfg(1'b0, 1'b1, 8'h18 + 8'(4 * ((i + 3) % 4)), 32'hFFFF_FFFF);
		end
		for (int i = 0; i < 4; i++) begin
			rdchk(8'h18 + 8'(4 * i), {16'h1000 + 16'(i), 16'h0008});
		end
		chk("tgt_prefetch", 32'h0000_000F, {28'h0000000, tgt_prefetch});
		hits(32'h1002_0010, 8'h04);
		hits(32'h1000_0010, 8'h01);
		@(posedge clk_sys);
		tgt_bs <= 16'h0001;
		hits(32'h1001_0010, 8'h03);
		cfg(1'b1, 1'b1, 8'h10, 32'h2000_0008);
		rdchk(8'h10, 32'h0000_0000);
		@(posedge clk_sys);
		msg_we <= 1'b1;
		cfg(1'b1, 1'b1, 8'h10, 32'h2000_0008);
		rdchk(8'h10, 32'h2000_0008);
		hits(32'h2000_0FFC, 8'hC0);
		hits(32'h2000_1000, 8'hA0);
		@(posedge clk_sys);
		msg_bs <= 4'h1;
		hits(32'h2001_0010, 8'hA0);
		@(posedge clk_sys);
		primary_port <= 1'b0;
		rdchk(8'h10, 32'h0000_0000);
		hits(32'h2000_0100, 8'h00);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		eel <= 1'b0;
		primary_port <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("tgt_prefetch", 32'h0000_000F, {28'h0000000, tgt_prefetch});
		rdchk(8'h2C, 32'h0000_0000);
		rdchk(8'h10, 32'h0000_0008);
		rdchk(8'h18, 32'h0000_0008);
		hits(32'h2000_0100, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
